/* logic/nvs_i2c_slave.sv */
`timescale 1ns/10ps
`default_nettype none
module nvs_i2c_slave #(
  parameter logic [3:0] P_TYPE_CODE = nvs_pkg::TYPE_CODE,
  parameter int P_GLITCH_CYC = nvs_pkg::GLITCH_CYC,
  parameter int P_FIFO_DEPTH = nvs_pkg::FIFO_DEPTH,
  parameter int P_MEM_WORDS = nvs_pkg::MEM_WORDS
) (
  input wire logic i_clk, // system clock
  input wire logic i_reset, // synchronous reset
  input wire logic i_scl, // serial clock pin
  input wire logic i_sda, // serial data pin level
  input wire logic [nvs_pkg::DEV_SEL_W-1:0] i_device_select_pins, // select straps
  input wire logic i_wp, // write protect pin
  output logic o_sda_out, // data drive value, always low
  output logic o_sda_oe, // high while pulling data low
  output logic o_scl_oe, // clock drive enable, never set
  output logic o_busy, // transfer in progress, from start until stop or release
  output logic o_wr_done, // pulse: byte stored in array
  output logic o_wr_blocked // pulse: byte refused by protect
);

  localparam int AW = nvs_pkg::MEM_AW;
  localparam int BW = nvs_pkg::BYTE_W;
  localparam int FW = $clog2(P_GLITCH_CYC + 1);
  localparam int PW = $clog2(P_FIFO_DEPTH);

  // ==========================================================
  // elaboration checks
  if (P_GLITCH_CYC < 1) begin : g_chk_glitch
    $error("glitch filter needs at least one cycle");
  end
  if (P_FIFO_DEPTH < 2 || P_FIFO_DEPTH != (1 << PW)) begin : g_chk_fifo
    $error("buffer depth must be a power of two of at least two");
  end
  if (P_MEM_WORDS != (1 << AW)) begin : g_chk_mem
    $error("array size must match the address width");
  end

  // ==========================================================
  // pin synchronisers
  logic [nvs_pkg::SYNC_W-1:0] meta_q;
  logic [nvs_pkg::SYNC_W-1:0] sync_q;

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      meta_q <= nvs_pkg::SYNC_RST;
      sync_q <= nvs_pkg::SYNC_RST;
    end else begin
      meta_q <= {i_scl, i_sda, i_device_select_pins, i_wp};
      sync_q <= meta_q;
    end
  end

  logic [nvs_pkg::DEV_SEL_W-1:0] dev_sel;
  logic wp;
  assign dev_sel = sync_q[nvs_pkg::SYNC_SEL_LSB +: nvs_pkg::DEV_SEL_W];
  assign wp = sync_q[nvs_pkg::SYNC_WP];

  // ==========================================================
  // glitch filters: bit 1 clock, bit 0 data
  logic [1:0] filt_q;
  logic [1:0] prev_q;

  for (genvar g = 0; g < 2; g++) begin : g_filt
    logic [FW-1:0] cnt_q;
    logic smp;
    assign smp = sync_q[nvs_pkg::SYNC_SDA + g];
    always_ff @(posedge i_clk) begin
      if (i_reset) begin
        cnt_q <= '0;
        filt_q[g] <= 1'b1;
      end else if (smp == filt_q[g]) begin
        cnt_q <= '0;
      end else if (cnt_q == FW'(P_GLITCH_CYC - 1)) begin
        cnt_q <= '0;
        filt_q[g] <= smp;
      end else begin
        cnt_q <= cnt_q + FW'(1);
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      prev_q <= 2'h3;
    end else begin
      prev_q <= filt_q;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic sda_f;
  logic start_det;
  logic stop_det;
  assign sda_f = filt_q[0];
  assign scl_rise = filt_q[1] & ~prev_q[1];
  assign scl_fall = ~filt_q[1] & prev_q[1];
  // data moving with clock high is start or stop only
  assign start_det = filt_q[1] & prev_q[1] & prev_q[0] & ~filt_q[0];
  assign stop_det = filt_q[1] & prev_q[1] & ~prev_q[0] & filt_q[0];

  // ==========================================================
  // protocol state
  nvs_pkg::nvs_state_t state_q;
  nvs_pkg::nvs_byte_t kind_q;
  logic [3:0] bit_q;
  logic ackph_q;
  logic rw_q;
  logic nack_q;
  logic [BW-1:0] sr_q;
  logic oe_q;
  logic [AW-1:0] addr_q;
  logic [AW-1:0] fptr_q;
  logic [BW-1:0] fifo_out;
  logic fifo_take;

  logic byte_end;
  logic sel_ok;
  logic rd_start;
  logic wr_byte;
  logic mem_we;
  logic pop_req;

  assign byte_end = (state_q == nvs_pkg::ST_RX) & scl_fall & ~ackph_q & (bit_q == nvs_pkg::ACK_BIT);
  // type field then select bits high first
  assign sel_ok = (sr_q[BW-1:nvs_pkg::ADB_TYPE_LSB] == P_TYPE_CODE)
                & (sr_q[nvs_pkg::ADB_SEL_LSB +: nvs_pkg::DEV_SEL_W] == dev_sel);
  assign rd_start = byte_end & (kind_q == nvs_pkg::BY_DEV) & sel_ok & sr_q[nvs_pkg::ADB_DIR_BIT];
  assign wr_byte = byte_end & (kind_q == nvs_pkg::BY_DATA);
  // protect low lets every location be written
  assign mem_we = wr_byte & ~wp;
  assign pop_req = scl_fall & ackph_q
                 & (((state_q == nvs_pkg::ST_RX) & (kind_q == nvs_pkg::BY_DEV) & rw_q)
                 | ((state_q == nvs_pkg::ST_TX) & ~nack_q));

  // slave only; no start, no clock drive
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      state_q <= nvs_pkg::ST_IDLE;
      kind_q <= nvs_pkg::BY_DEV;
      bit_q <= '0;
      ackph_q <= 1'b0;
      rw_q <= 1'b0;
      nack_q <= 1'b0;
      sr_q <= nvs_pkg::SHIFT_RST;
      oe_q <= 1'b0;
    // stop ends a read and releases
    end else if (stop_det) begin
      state_q <= nvs_pkg::ST_IDLE;
      ackph_q <= 1'b0;
      rw_q <= 1'b0;
      oe_q <= 1'b0;
    // start taken at once, no write wait
    end else if (start_det) begin
      state_q <= nvs_pkg::ST_RX;
      kind_q <= nvs_pkg::BY_DEV;
      bit_q <= '0;
      ackph_q <= 1'b0;
      rw_q <= 1'b0;
      oe_q <= 1'b0;
    end else begin
      case (state_q)
        nvs_pkg::ST_RX: begin
          if (scl_rise && !ackph_q && bit_q != nvs_pkg::ACK_BIT) begin
            sr_q <= {sr_q[BW-2:0], sda_f};
            bit_q <= bit_q + 4'h1;
          end else if (byte_end) begin
            if (kind_q == nvs_pkg::BY_DEV && !sel_ok) begin
              state_q <= nvs_pkg::ST_IDLE;
            end else begin
              ackph_q <= 1'b1;
              oe_q <= 1'b1;
            end
            if (kind_q == nvs_pkg::BY_DEV) begin
              rw_q <= sr_q[nvs_pkg::ADB_DIR_BIT];
            end
          end else if (scl_fall && ackph_q) begin
            ackph_q <= 1'b0;
            bit_q <= '0;
            if (pop_req) begin
              state_q <= nvs_pkg::ST_TX;
              sr_q <= fifo_out;
              oe_q <= ~fifo_out[BW-1];
            end else begin
              oe_q <= 1'b0;
              case (kind_q)
                nvs_pkg::BY_DEV: kind_q <= nvs_pkg::BY_AHI;
                nvs_pkg::BY_AHI: kind_q <= nvs_pkg::BY_ALO;
                default: kind_q <= nvs_pkg::BY_DATA;
              endcase
            end
          end
        end
        nvs_pkg::ST_TX: begin
          if (ackph_q) begin
            if (scl_rise) begin
              nack_q <= sda_f;
            end else if (scl_fall) begin
              ackph_q <= 1'b0;
              bit_q <= '0;
              if (pop_req) begin
                sr_q <= fifo_out;
                oe_q <= ~fifo_out[BW-1];
              end else begin
                // released after a no-ack; wait for start or stop
                state_q <= nvs_pkg::ST_IDLE;
              end
            end
          end else if (scl_rise) begin
            bit_q <= bit_q + 4'h1;
          end else if (scl_fall) begin
            if (bit_q == nvs_pkg::ACK_BIT) begin
              oe_q <= 1'b0;
              ackph_q <= 1'b1;
            end else begin
              // change driven bit on falling clock
              sr_q <= {sr_q[BW-2:0], 1'b0};
              oe_q <= ~sr_q[BW-2];
            end
          end
        end
        default: begin
          state_q <= nvs_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // memory address
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      addr_q <= nvs_pkg::ADDR_RST;
    end else if (byte_end && kind_q == nvs_pkg::BY_AHI) begin
      // upper two bits of the high byte are ignored
      addr_q[AW-1:BW] <= sr_q[AW-BW-1:0];
    end else if (byte_end && kind_q == nvs_pkg::BY_ALO) begin
      addr_q[BW-1:0] <= sr_q;
    end else if (wr_byte || fifo_take) begin
      addr_q <= addr_q + AW'(1);
    end
  end

  // ==========================================================
  // array
  // byte-wide locations, each addressable
  logic [BW-1:0] mem_q [P_MEM_WORDS];

  always_ff @(posedge i_clk) begin
    if (mem_we) begin
      mem_q[addr_q] <= sr_q;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_wr_done <= 1'b0;
      o_wr_blocked <= 1'b0;
    end else begin
      o_wr_done <= mem_we;
      o_wr_blocked <= wr_byte & wp;
    end
  end

  // ==========================================================
  // read prefetch buffer
  logic [BW-1:0] fifo_q [P_FIFO_DEPTH];
  logic [PW:0] wptr_q;
  logic [PW:0] rptr_q;
  logic fill_valid;
  logic fill_ready;
  logic push;
  logic out_valid;

  // prefetch runs whatever the protect level
  assign fill_valid = rw_q;
  assign fill_ready = ~((wptr_q[PW] != rptr_q[PW]) & (wptr_q[PW-1:0] == rptr_q[PW-1:0]));
  assign push = fill_valid & fill_ready & ~rd_start;
  assign out_valid = (wptr_q != rptr_q);
  assign fifo_take = pop_req & out_valid;
  assign fifo_out = out_valid ? fifo_q[rptr_q[PW-1:0]] : nvs_pkg::IDLE_BYTE;

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      wptr_q <= '0;
      rptr_q <= '0;
      fptr_q <= nvs_pkg::ADDR_RST;
    end else if (rd_start) begin
      // a new read restarts fetching at the current address
      wptr_q <= '0;
      rptr_q <= '0;
      fptr_q <= addr_q;
    end else begin
      if (push) begin
        wptr_q <= wptr_q + (PW + 1)'(1);
        fptr_q <= fptr_q + AW'(1);
      end
      if (fifo_take) begin
        rptr_q <= rptr_q + (PW + 1)'(1);
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (push) begin
      fifo_q[wptr_q[PW-1:0]] <= mem_q[fptr_q];
    end
  end

  // ==========================================================
  // outputs
  // open drain, drive value fixed low
  assign o_sda_out = 1'b0;
  assign o_sda_oe = oe_q;
  assign o_scl_oe = 1'b0;
  assign o_busy = (state_q != nvs_pkg::ST_IDLE);

endmodule : nvs_i2c_slave
`default_nettype wire

/* logic/nvs_pkg.sv */
`default_nettype none
package nvs_pkg;

  // ==========================================================
  // memory array geometry
  localparam int MEM_WORDS = 16384;
  localparam int MEM_AW = 14;
  localparam int BYTE_W = 8;

  // ==========================================================
  // addressing byte layout: type[7:4] select[3:1] dir[0]
  localparam int DEV_SEL_W = 3;
  localparam int ADB_TYPE_LSB = 4;
  localparam int ADB_SEL_LSB = 1;
  localparam int ADB_DIR_BIT = 0;
  // type code value is arbitrary
  localparam logic [3:0] TYPE_CODE = 4'h6;
  // rising edges in a byte before the ninth clock
  localparam logic [3:0] ACK_BIT = 4'h8;

  // ==========================================================
  // pin synchroniser: {scl, sda, device_select_pins, wp}
  localparam int SYNC_W = 6;
  localparam int SYNC_SCL = 5;
  localparam int SYNC_SDA = 4;
  localparam int SYNC_SEL_LSB = 1;
  localparam int SYNC_WP = 0;
  localparam logic [5:0] SYNC_RST = 6'h30;

  // ==========================================================
  // reset values and empty-buffer read byte
  localparam logic [7:0] SHIFT_RST = 8'h00;
  localparam logic [13:0] ADDR_RST = 14'h0000;
  localparam logic [7:0] IDLE_BYTE = 8'hff;

  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int GLITCH_NS = 200;
  localparam int GLITCH_CYC = (GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FIFO_DEPTH = 2;

  // ==========================================================
  // types
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_RX,
    ST_TX
  } nvs_state_t;

  typedef enum logic [1:0] {
    BY_DEV,
    BY_AHI,
    BY_ALO,
    BY_DATA
  } nvs_byte_t;

endpackage : nvs_pkg
`default_nettype wire

/* dv/nvs_chk_asserts.sv */
`timescale 1ns/10ps
`default_nettype none
module nvs_chk #(
  parameter logic [3:0] P_TYPE_CODE = nvs_pkg::TYPE_CODE
) (
  input wire logic i_clk, // clock
  input wire logic i_reset, // sync reset
  input wire logic i_scl, // clock pin
  input wire logic i_sda, // data wire
  input wire logic [nvs_pkg::DEV_SEL_W-1:0] i_device_select_pins, // straps
  input wire logic i_wp, // protect pin
  input wire logic o_sda_out, // drive value
  input wire logic o_sda_oe, // data pull
  input wire logic o_scl_oe, // clock drive
  input wire logic o_busy, // busy
  input wire logic o_wr_done, // stored pulse
  input wire logic o_wr_blocked // refused pulse
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  // ==========================================================
  // raw pin edges, bit count since start
  logic scl_q, sda_q, oe_q, st_w, sp_w;
  logic [3:0] fall_q;
  logic [4:0] rise_q;
  logic [7:0] sh_q;
  // master edges only: the device's own pull is excluded
  assign st_w = scl_q && i_scl && sda_q && !i_sda && !o_sda_oe;
  assign sp_w = scl_q && i_scl && !sda_q && i_sda && !oe_q;
  always_ff @(posedge i_clk) begin
    scl_q <= i_scl;
    sda_q <= i_sda;
    oe_q <= o_sda_oe;
  end
  always_ff @(posedge i_clk) begin
    if (i_reset || (scl_q && !i_scl)) begin
      fall_q <= 4'h0;
    end else if (fall_q != 4'hf) begin
      fall_q <= fall_q + 4'h1;
    end
  end
  always_ff @(posedge i_clk) begin
    if (i_reset || st_w) begin
      rise_q <= 5'h00;
    end else if (!scl_q && i_scl) begin
      rise_q <= (rise_q == 5'h1f) ? rise_q : rise_q + 5'h01;
      sh_q <= {sh_q[6:0], i_sda};
    end
  end
  // ==========================================================
  // properties
  property p_no_scl;
    o_scl_oe == 1'b0;
  endproperty
  a_no_scl: assert property (p_no_scl) else $error("clock line driven");
  property p_open_drain;
    o_sda_oe |-> o_sda_out == 1'b0;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("data driven high");
  property p_sda_low;
    $changed(o_sda_oe) |-> !i_scl;
  endproperty
  a_sda_low: assert property (p_sda_low) else $error("data moved with clock high");
  property p_start;
    st_w |-> ##[3:8] o_busy;
  endproperty
  a_start: assert property (p_start) else $error("start not taken");
  property p_stop;
    sp_w |-> ##[3:8] !o_busy;
  endproperty
  a_stop: assert property (p_stop) else $error("stop not taken");
  property p_quiet;
    !o_busy |-> !o_sda_oe;
  endproperty
  a_quiet: assert property (p_quiet) else $error("data pulled while idle");
  property p_edge;
    ($rose(o_sda_oe) || ($fell(o_sda_oe) && o_busy)) |-> fall_q inside {[4'h2:4'h7]};
  endproperty
  a_edge: assert property (p_edge) else $error("drive moved off clock fall");
  property p_match;
    $rose(o_sda_oe) && rise_q == 5'h08 |-> sh_q[7:1] == {P_TYPE_CODE, i_device_select_pins};
  endproperty
  a_match: assert property (p_match) else $error("ack to foreign address");
  property p_wr_gate;
    o_wr_done |-> !i_wp;
  endproperty
  a_wr_gate: assert property (p_wr_gate) else $error("write while protected");
  property p_blk_gate;
    o_wr_blocked |-> i_wp;
  endproperty
  a_blk_gate: assert property (p_blk_gate) else $error("write refused unprotected");
  c_write: cover property (o_wr_done);
  c_block: cover property (o_wr_blocked);
  c_read: cover property ($rose(o_sda_oe) && rise_q == 5'h0a);
endmodule : nvs_chk
bind nvs_i2c_slave nvs_chk #(.P_TYPE_CODE(P_TYPE_CODE)) u_nvs_chk (
  .i_clk(i_clk), .i_reset(i_reset), .i_scl(i_scl), .i_sda(i_sda),
  .i_device_select_pins(i_device_select_pins), .i_wp(i_wp), .o_sda_out(o_sda_out),
  .o_sda_oe(o_sda_oe), .o_scl_oe(o_scl_oe), .o_busy(o_busy), .o_wr_done(o_wr_done),
  .o_wr_blocked(o_wr_blocked)
);
`default_nettype wire

/* dv/nvs_mst.sv */
`timescale 1ns/10ps
`default_nettype none
module nvs_mst (
  input wire logic i_clk, // pacing clock
  input wire logic i_sda, // resolved data wire
  output logic o_scl, // serial clock
  output logic o_sda_oe // high while pulling data
);
  int slow = 0;
  initial begin
    o_scl = 1'b1;
    o_sda_oe = 1'b0;
  end
  task automatic tk(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : tk
  task automatic start();
    o_sda_oe = 1'b0;
    // let the slave's late release settle before clock rises
    tk(4);
    o_scl = 1'b1;
    tk(4);
    o_sda_oe = 1'b1;
    tk(4);
    o_scl = 1'b0;
    tk(2);
  endtask : start
  task automatic stop();
    o_sda_oe = 1'b1;
    tk(4);
    o_scl = 1'b1;
    tk(4);
    o_sda_oe = 1'b0;
    tk(6);
  endtask : stop
  task automatic bit_io(input logic b, output logic r);
    o_sda_oe = ~b;
    // low phase outlasts the slave's answer delay, period is 8 clocks plus slow
    tk(4 + slow);
    o_scl = 1'b1;
    tk(1);
    r = i_sda;
    tk(1);
    o_scl = 1'b0;
    tk(2);
  endtask : bit_io
  task automatic put(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask : put
  task automatic get(output logic [7:0] d, input logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(~ack, r);
  endtask : get
endmodule : nvs_mst
`default_nettype wire

/* dv/testbench.sv */
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic wp = 1'b0;
  logic [2:0] pins = 3'h0;
  logic m_scl, m_oe, sda_out, sda_oe, scl_oe, busy, wr_done, wr_blocked, ak;
  logic [31:0] rng = 32'h38;
  logic [13:0] a;
  logic [7:0] mem [int];
  int n_errors = 0;
  int checks_done = 0;
  int n_done = 0;
  int n_blk = 0;
  int cyc = 0;
  int n;
  wire logic scl = m_scl & ~scl_oe;
  wire logic sda = ~(m_oe | (sda_oe & ~sda_out));
  initial begin
    forever #50 clk = ~clk;
  end
  nvs_i2c_slave u_nvs_i2c_slave (.i_clk(clk), .i_reset(reset), .i_scl(scl), .i_sda(sda),
    .i_device_select_pins(pins), .i_wp(wp), .o_sda_out(sda_out), .o_sda_oe(sda_oe),
    .o_scl_oe(scl_oe), .o_busy(busy), .o_wr_done(wr_done), .o_wr_blocked(wr_blocked));
  nvs_mst u_nvs_mst (.i_clk(clk), .i_sda(sda), .o_scl(m_scl), .o_sda_oe(m_oe));
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (wr_done === 1'b1) n_done <= n_done + 1;
    if (wr_blocked === 1'b1) n_blk <= n_blk + 1;
    if (cyc == 40000) begin
      n_errors = n_errors + 1;
      wrap_up();
    end
  end
  function automatic logic [7:0] rnd();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng[7:0];
  endfunction : rnd
  function automatic logic [7:0] dev(input logic [2:0] s, input logic rd);
    return {nvs_pkg::TYPE_CODE, s, rd};
  endfunction : dev
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic hdr(input logic [13:0] ad);
    u_nvs_mst.start();
    u_nvs_mst.put(dev(pins, 1'b0), ak);
    chk(ak, 1'b1);
    u_nvs_mst.put({2'h0, ad[13:8]}, ak);
    chk(ak, 1'b1);
    u_nvs_mst.put(ad[7:0], ak);
    chk(ak, 1'b1);
  endtask : hdr
  task automatic wr(input logic [13:0] ad, input int cnt);
    logic [7:0] d;
    int d0;
    int b0;
    d0 = n_done;
    b0 = n_blk;
    hdr(ad);
    for (int i = 0; i < cnt; i++) begin
      d = rnd();
      u_nvs_mst.put(d, ak);
      chk(ak, 1'b1);
      if (wp == 1'b0) mem[(int'(ad) + i) % nvs_pkg::MEM_WORDS] = d;
    end
    u_nvs_mst.stop();
    chk(busy, 1'b0);
    chk(16'(n_done - d0), 16'(wp ? 0 : cnt));
    chk(16'(n_blk - b0), 16'(wp ? cnt : 0));
  endtask : wr
  task automatic rd(input logic [13:0] ad, input int cnt);
    logic [7:0] d;
    hdr(ad);
    u_nvs_mst.start();
    u_nvs_mst.put(dev(pins, 1'b1), ak);
    chk(ak, 1'b1);
    for (int i = 0; i < cnt; i++) begin
      u_nvs_mst.get(d, i < cnt - 1);
      chk(d, mem[(int'(ad) + i) % nvs_pkg::MEM_WORDS]);
    end
    u_nvs_mst.stop();
    chk(busy, 1'b0);
  endtask : rd
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : wrap_up
  initial begin
    repeat (6) @(posedge clk);
    #1;
    reset = 1'b0;
    repeat (4) @(posedge clk);
    for (int p = 0; p < 8; p++) begin
      pins = p[2:0];
      u_nvs_mst.start();
      u_nvs_mst.put(dev(pins, 1'b0), ak);
      chk(ak, 1'b1);
      u_nvs_mst.start();
      u_nvs_mst.put(dev(pins ^ (3'h1 + 3'(rnd() % 8'h07)), 1'b0), ak);
      chk(ak, 1'b0);
      chk(busy, 1'b0);
      u_nvs_mst.start();
      u_nvs_mst.put({nvs_pkg::TYPE_CODE ^ 4'(rnd() % 8'h0f + 8'h01), pins, 1'b1}, ak);
      chk(ak, 1'b0);
      u_nvs_mst.stop();
    end
    $display("select test done");
    for (int k = 0; k < 5; k++) begin
      a = (k == 0) ? 14'h3fff : 14'({rnd(), rnd()});
      n = 3 + rnd() % 8'h03;
      wr(a, n);
      rd(a, n);
    end
    $display("write read test done");
    wp = 1'b1;
    wr(a, 3);
    u_nvs_mst.slow = 6;
    rd(a, 3);
    u_nvs_mst.slow = 0;
    wp = 1'b0;
    $display("protect and stall test done");
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
